//--- core/ohis_event_flags.sv
`timescale 1ns/1ns
`default_nettype none
module ohis_event_flags
  import ohis_pkg::*;
#(
  parameter bit SMI_PRESENT = 1'b1
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire ohis_reg_req_t reg_req,
  output ohis_reg_rsp_t reg_rsp,
  input wire logic [REG_W-1:0] interrupt_mask_register,
  input wire ohis_core_evt_t core_evt,
  input wire logic resume_line,
  input wire logic resume_functional_state,
  input wire logic sys_error_active,
  output logic host_irq,
  output logic system_mgmt_irq_pin_n,
  output logic processing_halt,
  output logic done_head_write_hold,
  output logic [OVERRUN_CNT_W-1:0] overrun_count,
  output logic [REG_W-1:0] interrupt_event_flags
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (EVENT_POS[NUM_EVENTS-1] != BIT_OWNERSHIP) begin : g_bad_map
    $error("ownership flag must be the last event slot");
  end

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  function automatic logic [REG_W-1:0] lane_mask(input logic [3:0] be);
    logic [REG_W-1:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  function automatic logic hits_flags(input ohis_reg_req_t r);
    return r.sel && (r.addr == OFS_EVENT_FLAGS);
  endfunction

  // ----------------------------------------------------------------
  // resume line synchroniser
  // ----------------------------------------------------------------
  logic resume_meta_r;
  logic resume_sync_r;
  logic resume_prev_r;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      resume_meta_r <= 1'b0;
      resume_sync_r <= 1'b0;
      resume_prev_r <= 1'b0;
    end else begin
      resume_meta_r <= resume_line;
      resume_sync_r <= resume_meta_r;
      resume_prev_r <= resume_sync_r;
    end
  end

  // ----------------------------------------------------------------
  // edge history of core levels
  // ----------------------------------------------------------------
  logic own_req_prev_r;
  logic frame_msb_prev_r;
  logic ovf_pending_r;
  logic ovf_pending_nxt;
  logic overrun_pending_r;
  logic overrun_pending_nxt;

  wire own_req_rise = core_evt.ownership_request_bit & ~own_req_prev_r;
  wire frame_msb_toggle = core_evt.frame_msb ^ frame_msb_prev_r;
  wire frame_upd = core_evt.shared_frame_updated;

  // a toggle or overrun seen in the update cycle itself sets at once
  assign ovf_pending_nxt = (ovf_pending_r | frame_msb_toggle) & ~frame_upd;
  assign overrun_pending_nxt = (overrun_pending_r | core_evt.sched_overrun) & ~frame_upd;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      own_req_prev_r <= 1'b0;
      frame_msb_prev_r <= 1'b0;
      ovf_pending_r <= 1'b0;
      overrun_pending_r <= 1'b0;
    end else begin
      own_req_prev_r <= core_evt.ownership_request_bit;
      frame_msb_prev_r <= core_evt.frame_msb;
      ovf_pending_r <= ovf_pending_nxt;
      overrun_pending_r <= overrun_pending_nxt;
    end
  end

  // ----------------------------------------------------------------
  // event set terms
  // ----------------------------------------------------------------
  logic [NUM_EVENTS-1:0] set_vec;
  logic [NUM_EVENTS-1:0] clr_vec;
  logic [NUM_EVENTS-1:0] zero_vec;
  logic [NUM_EVENTS-1:0] flag_vec;

  assign set_vec[0] = frame_upd & (overrun_pending_r | core_evt.sched_overrun);
  assign set_vec[1] = core_evt.done_head_written;
  assign set_vec[2] = core_evt.sof_issued;
  assign set_vec[3] = resume_sync_r & ~resume_prev_r & ~resume_functional_state;
  assign set_vec[4] = core_evt.sys_error;
  assign set_vec[5] = frame_upd & (ovf_pending_r | frame_msb_toggle);
  assign set_vec[6] = core_evt.root_hub_changed;
  assign set_vec[7] = own_req_rise;

  // ----------------------------------------------------------------
  // software write-one-to-clear
  // ----------------------------------------------------------------
  wire flags_write = hits_flags(reg_req) && reg_req.wr;
  wire [REG_W-1:0] clear_bits = flags_write ? (reg_req.wdata & lane_mask(reg_req.be)) : '0;

  // ----------------------------------------------------------------
  // sticky flag cells
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_EVENTS; g++) begin : g_flag
    assign clr_vec[g] = clear_bits[EVENT_POS[g]];
    assign zero_vec[g] = (EVENT_POS[g] == BIT_OWNERSHIP) && !SMI_PRESENT;
    ohis_flag_cell u_cell (
      .clk_sys(clk_sys),
      .reset(reset),
      .set_evt(set_vec[g]),
      .clear_req(clr_vec[g]),
      .keep_zero(zero_vec[g]),
      .flag(flag_vec[g])
    );
  end

  // reserved positions are never stored, so they read zero
  logic [REG_W-1:0] flags_word;
  always_comb begin
    flags_word = EVENT_FLAGS_RESET;
    for (int i = 0; i < NUM_EVENTS; i++) begin
      flags_word[EVENT_POS[i]] = flag_vec[i];
    end
  end

  // ----------------------------------------------------------------
  // interrupt request logic
  // ----------------------------------------------------------------
  wire master_on = interrupt_mask_register[BIT_MASTER_EN];
  wire [REG_W-1:0] host_pending = flags_word & interrupt_mask_register;
  // ownership goes to the management pin, not to the host interrupt
  wire host_src = |(host_pending[BIT_ROOT_HUB:BIT_OVERRUN]);
  wire host_irq_nxt = master_on & host_src;
  wire smi_nxt = host_pending[BIT_OWNERSHIP] && SMI_PRESENT;

  // ----------------------------------------------------------------
  // overrun counter
  // ----------------------------------------------------------------
  logic [OVERRUN_CNT_W-1:0] overrun_cnt_r;
  wire [OVERRUN_CNT_W-1:0] overrun_cnt_nxt = core_evt.sched_overrun ?
    OVERRUN_CNT_W'(overrun_cnt_r + OVERRUN_CNT_STEP) : overrun_cnt_r;

  // ----------------------------------------------------------------
  // fatal error halt machine
  // ----------------------------------------------------------------
  ohis_err_state_t err_state_r;
  ohis_err_state_t err_state_nxt;

  always_comb begin
    err_state_nxt = err_state_r;
    case (err_state_r)
      ERR_RUN: begin
        if (core_evt.sys_error) begin
          err_state_nxt = ERR_HALT;
        end
      end
      ERR_HALT: begin
        if (!sys_error_active && !core_evt.sys_error) begin
          err_state_nxt = ERR_RUN;
        end
      end
      default: begin
        err_state_nxt = ERR_HALT;
      end
    endcase
  end

  wire halt_nxt = (err_state_nxt == ERR_HALT);

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  // reads return the flags as they stand before this cycle's update
  wire [REG_W-1:0] rdata_nxt = hits_flags(reg_req) ? flags_word : '0;
  ohis_reg_rsp_t rsp_nxt;
  assign rsp_nxt.ack = reg_req.sel;
  assign rsp_nxt.rdata = (reg_req.sel && !reg_req.wr) ? rdata_nxt : '0;

  // ----------------------------------------------------------------
  // output flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      err_state_r <= ERR_RUN;
      overrun_cnt_r <= OVERRUN_CNT_RESET;
      host_irq <= 1'b0;
      system_mgmt_irq_pin_n <= 1'b1;
      processing_halt <= 1'b0;
      reg_rsp <= '0;
    end else begin
      err_state_r <= err_state_nxt;
      overrun_cnt_r <= overrun_cnt_nxt;
      host_irq <= host_irq_nxt;
      system_mgmt_irq_pin_n <= ~smi_nxt;
      processing_halt <= halt_nxt;
      reg_rsp <= rsp_nxt;
    end
  end

  assign overrun_count = overrun_cnt_r;

  assign done_head_write_hold = flag_vec[1];
  assign interrupt_event_flags = flags_word;

endmodule
`default_nettype wire

//--- core/ohis_flag_cell.sv
`timescale 1ns/1ns
`default_nettype none
module ohis_flag_cell (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic set_evt,
  input wire logic clear_req,
  input wire logic keep_zero,
  output logic flag
);

  // set beats clear so an event in the clearing cycle survives
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      flag <= 1'b0;
    end else if (keep_zero) begin
      flag <= 1'b0;
    end else begin
      flag <= (flag & ~clear_req) | set_evt;
    end
  end

endmodule
`default_nettype wire

//--- core/ohis_pkg.sv
package ohis_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int REG_W = 32;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_EVENT_FLAGS = 8'h0C;
  localparam logic [REG_W-1:0] EVENT_FLAGS_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // field positions, shared by the flag register and the mask input
  // ----------------------------------------------------------------
  localparam int BIT_OVERRUN = 0;
  localparam int BIT_DONE_HEAD = 1;
  localparam int BIT_FRAME_START = 2;
  localparam int BIT_RESUME = 3;
  localparam int BIT_FATAL = 4;
  localparam int BIT_FRAME_OVF = 5;
  localparam int BIT_ROOT_HUB = 6;
  localparam int BIT_OWNERSHIP = 30;
  localparam int BIT_MASTER_EN = 31;

  localparam int NUM_EVENTS = 8;
  localparam int EVENT_POS [NUM_EVENTS] = '{0, 1, 2, 3, 4, 5, 6, 30};

  // ----------------------------------------------------------------
  // overrun counter and bit-15 of the frame counter
  // ----------------------------------------------------------------
  localparam int OVERRUN_CNT_W = 2;
  localparam logic [OVERRUN_CNT_W-1:0] OVERRUN_CNT_RESET = 2'h0;
  localparam logic [OVERRUN_CNT_W-1:0] OVERRUN_CNT_STEP = 2'h1;
  localparam int FRAME_MSB = 15;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sel;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [3:0] be;
    logic [REG_W-1:0] wdata;
  } ohis_reg_req_t;

  typedef struct packed {
    logic ack;
    logic [REG_W-1:0] rdata;
  } ohis_reg_rsp_t;

  typedef struct packed {
    logic ownership_request_bit;
    logic root_hub_changed;
    logic frame_msb;
    logic shared_frame_updated;
    logic sys_error;
    logic sched_overrun;
    logic sof_issued;
    logic done_head_written;
  } ohis_core_evt_t;

  typedef enum logic [1:0] {
    ERR_RUN = 2'b01,
    ERR_HALT = 2'b10
  } ohis_err_state_t;

endpackage

//--- verification/ohis_event_flags_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module ohis_event_flags_monitor
  import ohis_pkg::*;
#(
  parameter bit SMI_PRESENT = 1'b1
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire ohis_reg_req_t reg_req,
  input wire ohis_reg_rsp_t reg_rsp,
  input wire logic [REG_W-1:0] interrupt_mask_register,
  input wire ohis_core_evt_t core_evt,
  input wire logic resume_line,
  input wire logic resume_functional_state,
  input wire logic sys_error_active,
  input wire logic host_irq,
  input wire logic system_mgmt_irq_pin_n,
  input wire logic processing_halt,
  input wire logic done_head_write_hold,
  input wire logic [OVERRUN_CNT_W-1:0] overrun_count,
  input wire logic [REG_W-1:0] interrupt_event_flags
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire logic [REG_W-1:0] fl = interrupt_event_flags;
  wire logic [REG_W-1:0] msk = interrupt_mask_register;
  wire logic irq_cause = (|(fl[6:0] & msk[6:0])) && msk[BIT_MASTER_EN];
  wire logic clr_wr = reg_req.sel && reg_req.wr && (reg_req.addr == OFS_EVENT_FLAGS);
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  // resume line is synchronised, so the flag trails the rise by a few cycles
  sequence s_resume_quiet;
    $rose(resume_line) ##0 (resume_line && !resume_functional_state) [*4];
  endsequence
  sequence s_err_over;
    processing_halt && !sys_error_active && !core_evt.sys_error;
  endsequence
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_rootchg_sets_flag: assert property (core_evt.root_hub_changed |=> fl[BIT_ROOT_HUB])
    else $error("root hub change flag not set");
  a_error_sets_halt: assert property (core_evt.sys_error |=> fl[BIT_FATAL] && processing_halt)
    else $error("fatal error flag or halt missing");
  a_halt_released: assert property (s_err_over |=> !processing_halt)
    else $error("halt held after error corrected");
  a_sof_sets_flag: assert property (core_evt.sof_issued |=> fl[BIT_FRAME_START])
    else $error("frame start flag not set");
  a_done_head_flag: assert property (core_evt.done_head_written |=> fl[BIT_DONE_HEAD])
    else $error("done head flag not set");
  a_hold_tracks_flag: assert property (done_head_write_hold == fl[BIT_DONE_HEAD])
    else $error("done head hold differs from flag");
  a_hold_until_clear: assert property (done_head_write_hold && !clr_wr |=> done_head_write_hold)
    else $error("done head hold dropped without clear");
  a_owner_sets_flag: assert property (SMI_PRESENT && $rose(core_evt.ownership_request_bit) |=> fl[BIT_OWNERSHIP])
    else $error("ownership change flag not set");
  a_no_pin_zero: assert property (!SMI_PRESENT |-> !fl[BIT_OWNERSHIP] && system_mgmt_irq_pin_n)
    else $error("ownership flag set without management pin");
  a_smi_follows_flag: assert property (fl[BIT_OWNERSHIP] && msk[BIT_OWNERSHIP] |=> !system_mgmt_irq_pin_n)
    else $error("management interrupt not raised");
  a_irq_level_match: assert property (1'b1 |=> host_irq == $past(irq_cause))
    else $error("host interrupt level wrong");
  a_flag_never_drops: assert property (|($past(fl) & ~fl) |-> $past(clr_wr))
    else $error("flag dropped without write");
  a_reserved_zero: assert property ((fl & 32'hBFFF_FF80) == '0)
    else $error("reserved flag bit set");
  a_clear_by_one: assert property (clr_wr && reg_req.be == 4'hF && core_evt == '0 |=>
    (fl & $past(reg_req.wdata) & ~32'h0000_0008) == '0) else $error("flag not cleared by one");
  a_overrun_counts: assert property (core_evt.sched_overrun |=>
    overrun_count == 2'($past(overrun_count) + 2'h1)) else $error("overrun count step wrong");
  a_resume_sets_flag: assert property (s_resume_quiet |-> ##[0:2] fl[BIT_RESUME])
    else $error("resume flag not set");
  a_no_sw_resume: assert property (resume_functional_state [*6] |-> !$rose(fl[BIT_RESUME]))
    else $error("resume flag set in software resume");
endmodule
bind ohis_event_flags ohis_event_flags_monitor #(.SMI_PRESENT(SMI_PRESENT)) u_mon (.clk_sys(clk_sys),
  .reset(reset), .reg_req(reg_req),
  .reg_rsp(reg_rsp), .interrupt_mask_register(interrupt_mask_register), .core_evt(core_evt),
  .resume_line(resume_line), .resume_functional_state(resume_functional_state),
  .sys_error_active(sys_error_active), .host_irq(host_irq), .system_mgmt_irq_pin_n(system_mgmt_irq_pin_n),
  .processing_halt(processing_halt), .done_head_write_hold(done_head_write_hold),
  .overrun_count(overrun_count), .interrupt_event_flags(interrupt_event_flags));
`default_nettype wire

//--- verification/tb_ohis_event_flags.sv
`timescale 1ns/1ns
`default_nettype none
module tb_ohis_event_flags
  import ohis_pkg::*;
();
  typedef struct packed {logic [7:0] evt; logic [31:0] flag;} ohis_row_t;
  // overrun row comes before the frame row: the frame bit toggling back leaves an update pending
  localparam ohis_row_t ROWS [7] = '{'{8'h40, 32'h40}, '{8'h08, 32'h10}, '{8'h14, 32'h01}, '{8'h02, 32'h04},
    '{8'h01, 32'h02}, '{8'h80, 32'h4000_0000}, '{8'h30, 32'h20}};
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  ohis_reg_req_t reg_req = '0;
  ohis_reg_rsp_t reg_rsp;
  ohis_core_evt_t core_evt = '0;
  logic [31:0] mask = 32'hC000_007F;
  logic resume_line = 1'b0;
  logic rfs = 1'b0;
  logic err_act = 1'b0;
  logic host_irq, smi_n, halt, hold;
  logic [1:0] cnt;
  logic [31:0] flags, rd;
  logic smi_ns;
  logic [31:0] flags_ns;
  int miscompares = 0;
  int checks = 0;
  ohis_event_flags #(.SMI_PRESENT(1'b1)) uut (.clk_sys(clk_sys), .reset(reset), .reg_req(reg_req),
    .reg_rsp(reg_rsp), .interrupt_mask_register(mask), .core_evt(core_evt), .resume_line(resume_line),
    .resume_functional_state(rfs), .sys_error_active(err_act), .host_irq(host_irq),
    .system_mgmt_irq_pin_n(smi_n), .processing_halt(halt), .done_head_write_hold(hold),
    .overrun_count(cnt), .interrupt_event_flags(flags));
  // second copy without the management pin, fed the same stimulus
  ohis_event_flags #(.SMI_PRESENT(1'b0)) uut_nosmi (.clk_sys(clk_sys), .reset(reset), .reg_req(reg_req),
    .reg_rsp(), .interrupt_mask_register(mask), .core_evt(core_evt), .resume_line(resume_line),
    .resume_functional_state(rfs), .sys_error_active(err_act), .host_irq(),
    .system_mgmt_irq_pin_n(smi_ns), .processing_halt(), .done_head_write_hold(),
    .overrun_count(), .interrupt_event_flags(flags_ns));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // one-cycle select; ack and data are taken at the next falling edge
  // an idle edge follows so back-to-back calls never reassign the request at once
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    reg_req = '{sel: 1'b1, wr: wr, addr: addr, be: 4'hF, wdata: data};
    cyc(1);
    reg_req = '0;
    chk("ack", 32'h1, reg_rsp.ack);
    rd = reg_rsp.rdata;
    cyc(1);
  endtask
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------------------------------
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    #8000;
    miscompares++;
    $display("watchdog expired");
    report_and_stop();
  end
  initial begin
    cyc(6);
    reset = 1'b0;
    for (int i = 0; i < 7; i++) begin
      core_evt = ROWS[i].evt;
      cyc(1);
      core_evt = '0;
      cyc(1);
      chk("flags", ROWS[i].flag, flags);
      chk("host_irq", |ROWS[i].flag[6:0], host_irq);
      chk("smi_n", !ROWS[i].flag[30], smi_n);
      chk("hold", ROWS[i].flag[1], hold);
      chk("flags_nosmi", ROWS[i].flag & 32'hBFFF_FFFF, flags_ns);
      chk("smi_nosmi", 32'h1, smi_ns);
      bus(1'b0, OFS_EVENT_FLAGS, '0);
      chk("read", ROWS[i].flag, rd);
      bus(1'b1, OFS_EVENT_FLAGS, ROWS[i].flag);
      chk("cleared", 32'h0, flags);
      $display("test row %0d done", i);
    end
    chk("count", 32'h1, cnt);
    mask = 32'h0000_007F;
    core_evt.sof_issued = 1'b1;
    cyc(1);
    core_evt = '0;
    cyc(3);
    chk("irq_mie_off", 32'h0, host_irq);
    mask = 32'h8000_007F;
    cyc(2);
    chk("irq_level", 32'h1, host_irq);
    bus(1'b1, OFS_EVENT_FLAGS, 32'h0);
    bus(1'b1, 8'h20, 32'h04);
    bus(1'b0, 8'h20, '0);
    chk("unmapped_read", 32'h0, rd);
    chk("write_zero", 32'h04, flags);
    bus(1'b1, OFS_EVENT_FLAGS, 32'h04);
    cyc(1);
    chk("irq_drop", 32'h0, host_irq);
    $display("test enable done");
    resume_line = 1'b1;
    cyc(6);
    chk("resume", 32'h08, flags);
    bus(1'b1, OFS_EVENT_FLAGS, 32'h08);
    resume_line = 1'b0;
    rfs = 1'b1;
    cyc(3);
    resume_line = 1'b1;
    cyc(6);
    chk("sw_resume", 32'h0, flags);
    resume_line = 1'b0;
    rfs = 1'b0;
    $display("test resume done");
    err_act = 1'b1;
    core_evt.sys_error = 1'b1;
    cyc(1);
    core_evt = '0;
    cyc(3);
    chk("halt", 32'h1, halt);
    err_act = 1'b0;
    cyc(2);
    chk("halt_end", 32'h0, halt);
    $display("test halt done");
    core_evt = 8'h14;
    cyc(1);
    core_evt = 8'h04;
    cyc(2);
    core_evt = '0;
    cyc(1);
    chk("count_wrap", 32'h0, cnt);
    chk("overrun_flag", 32'h1, flags[BIT_OVERRUN]);
    $display("test overrun done");
    // fatal flag is still set: the reset below clears it with the others
    reset = 1'b1;
    cyc(2);
    reset = 1'b0;
    cyc(1);
    chk("reset_flags", EVENT_FLAGS_RESET, flags);
    chk("reset_outputs", 32'h04, {halt, host_irq, smi_n, cnt});
    bus(1'b0, OFS_EVENT_FLAGS, '0);
    chk("reset_read", EVENT_FLAGS_RESET, rd);
    $display("test reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
